// file: src/att_top.sv
// Purpose: timeout and setup registers of a two-channel adaptive threshold tracker
// Assumes: serial front end delivers pointer/write/data on sys_clk
// Notes:   converter, averaging and status logic live outside
`timescale 1ns/100ps
`default_nettype none
`include "att_defs.svh"

// What this block does
// [R1] timeouts only run while the channel is in adaptive threshold mode
// [R2] approaching timeout starts when data leaves band toward the threshold
// [R3] approaching timeout elapses after 2^upper-nibble conversions
// [R4] receding timeout starts when data leaves band away from threshold
// [R5] receding timeout never runs in window threshold mode
// [R6] receding timeout elapses after 2^lower-nibble conversions
// [R7] on timeout the average is loaded with the newest conversion result
// [R8] a whole timeout register of zero disables both timeouts
// [R9] 8-bit read/write timeout register per channel at 0x0A and 0x0D
// [R10] timeout registers reset to 0x86: approach 8, recede 6
// [R11] 8-bit read/write setup register at 0x0B and 0x0E, reset 0x0B
// [R12] setup: range high bit7, range low bit6, bit5 zero, hyst bit4, settle 3:0
// [R13] range bits select input range and offset DAC step size
// [R14] timeout overwrites the average directly, erasing history
// [R15] thresholds sit sensitivity above and below the average
// [R16] a count clears when data returns inside the band
// [R17] each count advances once per finished conversion on its own channel
module att_top #(
   parameter int DATA_W = 12,
   parameter int SENS_W = 8
) (
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   input  wire logic                   clk_en,
   input  wire logic [7:0]             reg_addr,
   input  wire logic                   reg_wr,
   input  wire logic [7:0]             reg_wdata,
   output logic      [7:0]             reg_rdata,
   input  wire logic                   conv_done,
   input  wire logic                   conv_ch,
   input  wire logic [DATA_W-1:0]      conv_data,
   input  wire logic                   ch1_adaptive_en,
   input  wire att_pkg::att_thr_mode_t ch1_thr_mode,
   input  wire logic [DATA_W-1:0]      ch1_average,
   input  wire logic [SENS_W-1:0]      ch1_sensitivity,
   input  wire logic                   ch2_adaptive_en,
   input  wire att_pkg::att_thr_mode_t ch2_thr_mode,
   input  wire logic [DATA_W-1:0]      ch2_average,
   input  wire logic [SENS_W-1:0]      ch2_sensitivity,
   output logic                        ch1_avg_load,
   output logic      [DATA_W-1:0]      ch1_avg_load_value,
   output logic      [DATA_W-1:0]      ch1_pos_thr,
   output logic      [DATA_W-1:0]      ch1_neg_thr,
   output logic                        ch2_avg_load,
   output logic      [DATA_W-1:0]      ch2_avg_load_value,
   output logic      [DATA_W-1:0]      ch2_pos_thr,
   output logic      [DATA_W-1:0]      ch2_neg_thr,
   output logic                        ch1_range_sel_hi,
   output logic                        ch1_range_sel_lo,
   output logic                        ch1_hyst_en,
   output logic      [3:0]             ch1_threshold_settle_field,
   output logic                        ch2_range_sel_hi,
   output logic                        ch2_range_sel_lo,
   output logic                        ch2_hyst_en,
   output logic      [3:0]             ch2_threshold_settle_field
);

   // ----------------------------------------
   // register decode
   // ----------------------------------------
   logic [7:0] ch1_timeout_counts;
   logic [7:0] ch1_setup;
   logic [7:0] ch2_timeout_counts;
   logic [7:0] ch2_setup;

   wire logic hit_t1 = reg_addr == `ATT_ADDR_CH1_TMO;   // see [R9]
   wire logic hit_s1 = reg_addr == `ATT_ADDR_CH1_SETUP; // see [R11]
   wire logic hit_t2 = reg_addr == `ATT_ADDR_CH2_TMO;   // see [R9]
   wire logic hit_s2 = reg_addr == `ATT_ADDR_CH2_SETUP; // see [R11]
   // unused bit is kept zero on write
   wire logic [7:0] setup_wdata = reg_wdata & `ATT_SETUP_WMASK; // see [R12]
   wire logic [7:0] next_rdata  = hit_t1 ? ch1_timeout_counts :
                                  hit_s1 ? ch1_setup :
                                  hit_t2 ? ch2_timeout_counts :
                                  hit_s2 ? ch2_setup : 8'h00;
   wire logic conv1 = conv_done && !conv_ch; // see [R17]
   wire logic conv2 = conv_done && conv_ch;  // see [R17]

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ch1_timeout_counts <= `ATT_TMO_RESET;   // see [R10]
         ch2_timeout_counts <= `ATT_TMO_RESET;   // see [R10]
         ch1_setup          <= `ATT_SETUP_RESET; // see [R11]
         ch2_setup          <= `ATT_SETUP_RESET; // see [R11]
      end else if (clk_en && reg_wr) begin
         if (hit_t1) ch1_timeout_counts <= reg_wdata;
         if (hit_t2) ch2_timeout_counts <= reg_wdata;
         if (hit_s1) ch1_setup <= setup_wdata;
         if (hit_s2) ch2_setup <= setup_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= next_rdata;
      end
   end

   // setup fields go straight out of the register flops
   assign ch1_range_sel_hi           = ch1_setup[`ATT_RNG_HI_BIT]; // see [R12] see [R13]
   assign ch1_range_sel_lo           = ch1_setup[`ATT_RNG_LO_BIT]; // see [R12] see [R13]
   assign ch1_hyst_en                = ch1_setup[`ATT_HYST_BIT];
   assign ch1_threshold_settle_field = ch1_setup[`ATT_SETTLE_MSB:`ATT_SETTLE_LSB];
   assign ch2_range_sel_hi           = ch2_setup[`ATT_RNG_HI_BIT]; // see [R12] see [R13]
   assign ch2_range_sel_lo           = ch2_setup[`ATT_RNG_LO_BIT]; // see [R12] see [R13]
   assign ch2_hyst_en                = ch2_setup[`ATT_HYST_BIT];
   assign ch2_threshold_settle_field = ch2_setup[`ATT_SETTLE_MSB:`ATT_SETTLE_LSB];

   // ----------------------------------------
   // channels
   // ----------------------------------------
   att_chan_timeout #(.DATA_W(DATA_W), .SENS_W(SENS_W)) u_ch1 (
      .sys_clk        (sys_clk),
      .rst            (rst),
      .clk_en         (clk_en),
      .conv_done      (conv1),
      .conv_data      (conv_data),
      .average        (ch1_average),
      .sensitivity    (ch1_sensitivity),
      .adaptive_en    (ch1_adaptive_en),
      .thr_mode       (ch1_thr_mode),
      .timeout_cfg    (ch1_timeout_counts),
      .avg_load       (ch1_avg_load),
      .avg_load_value (ch1_avg_load_value),
      .pos_thr        (ch1_pos_thr),
      .neg_thr        (ch1_neg_thr),
      .tmo_state      (),
      .tmo_count      ()
   );

   att_chan_timeout #(.DATA_W(DATA_W), .SENS_W(SENS_W)) u_ch2 (
      .sys_clk        (sys_clk),
      .rst            (rst),
      .clk_en         (clk_en),
      .conv_done      (conv2),
      .conv_data      (conv_data),
      .average        (ch2_average),
      .sensitivity    (ch2_sensitivity),
      .adaptive_en    (ch2_adaptive_en),
      .thr_mode       (ch2_thr_mode),
      .timeout_cfg    (ch2_timeout_counts),
      .avg_load       (ch2_avg_load),
      .avg_load_value (ch2_avg_load_value),
      .pos_thr        (ch2_pos_thr),
      .neg_thr        (ch2_neg_thr),
      .tmo_state      (),
      .tmo_count      ()
   );

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // register port checks
   // ----------------------------------------

   a_tmo_write_lands: assert property (clk_en && reg_wr && hit_t2 |=>
      ch2_timeout_counts == $past(reg_wdata)) // see [R9]
      else $error("channel two timeout write lost");
   a_setup_bit5_zero: assert property (ch1_setup[5] == 1'b0 && ch2_setup[5] == 1'b0) // see [R12]
      else $error("setup unused bit set");
   a_reset_values: assert property ($fell(rst) |-> ch1_timeout_counts == 8'h86
      && ch1_setup == 8'h0B) // see [R10]
      else $error("wrong register reset value");
   a_read_unmapped: assert property (clk_en && !hit_t1 && !hit_s1 && !hit_t2 && !hit_s2
      |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_read_setup: assert property ( // see [R11]
      clk_en && hit_s1 && !reg_wr |=> reg_rdata == $past(ch1_setup))
      else $error("setup read mismatch");
   a_read_setup2: assert property ( // see [R11]
      clk_en && hit_s2 && !reg_wr |=> reg_rdata == $past(ch2_setup))
      else $error("setup2 read mismatch");
   a_read_timeout: assert property ( // see [R9]
      clk_en && hit_t1 && !reg_wr |=> reg_rdata == $past(ch1_timeout_counts))
      else $error("timeout read mismatch");

   a_tmo1_write_lands: assert property ( // see [R9]
      clk_en && reg_wr && hit_t1 |=> ch1_timeout_counts == $past(reg_wdata))
      else $error("channel one timeout write lost");
   a_setup_write_mask: assert property ( // see [R12]
      clk_en && reg_wr && hit_s2 |=> ch2_setup == ($past(reg_wdata) & `ATT_SETUP_WMASK))
      else $error("setup write not masked");

   a_reset_values2: assert property ( // see [R10] see [R11]
      $fell(rst) |-> ch2_timeout_counts == 8'h86 && ch2_setup == 8'h0B
      && reg_rdata == 8'h00)
      else $error("wrong channel two reset value");

   // ----------------------------------------
   // channel checks
   // ----------------------------------------
   a_load_own_chan: assert property (ch1_avg_load |-> $past(conv_done && !conv_ch)) // see [R17]
      else $error("channel one loaded on other channel conversion");
   a_load_own_chan2: assert property ( // see [R17]
      ch2_avg_load |-> $past(conv_done && conv_ch))
      else $error("channel two loaded on other channel conversion");
   a_freeze_holds: assert property (
      !clk_en |=> $stable(ch1_setup) && $stable(reg_rdata) && $stable(ch1_avg_load))
      else $error("state moved while frozen");

   c_write_setup: cover property (clk_en && reg_wr && hit_s2);
   c_both_loads: cover property (ch1_avg_load ##[1:20] ch2_avg_load);

endmodule : att_top
`default_nettype wire

// file: pkg/att_defs.svh
// Purpose: offsets, field positions and reset values of the timeout/setup registers
// Assumes: 8-bit register pointer, 8-bit registers
// Notes:   definitions only
`ifndef ATT_DEFS_SVH
`define ATT_DEFS_SVH

// ----------------------------------------
// register pointers
// ----------------------------------------
`define ATT_ADDR_CH1_TMO   8'h0A
`define ATT_ADDR_CH1_SETUP 8'h0B
`define ATT_ADDR_CH2_TMO   8'h0D
`define ATT_ADDR_CH2_SETUP 8'h0E

// ----------------------------------------
// reset values
// ----------------------------------------
`define ATT_TMO_RESET      8'h86
`define ATT_SETUP_RESET    8'h0B

// ----------------------------------------
// field positions
// ----------------------------------------
`define ATT_APR_MSB        7
`define ATT_APR_LSB        4
`define ATT_REC_MSB        3
`define ATT_REC_LSB        0
`define ATT_RNG_HI_BIT     7
`define ATT_RNG_LO_BIT     6
`define ATT_HYST_BIT       4
`define ATT_SETTLE_MSB     3
`define ATT_SETTLE_LSB     0
`define ATT_SETUP_WMASK    8'hDF

`endif

// file: pkg/att_pkg.sv
// Purpose: types shared by the adaptive threshold timeout logic
// Assumes: nothing
// Notes:   threshold mode encoding is local to this block
package att_pkg;

   typedef enum logic [1:0] {
      ATT_THR_POS = 2'b00,
      ATT_THR_NEG = 2'b01,
      ATT_THR_WIN = 2'b10
   } att_thr_mode_t;

   typedef enum logic [1:0] {
      ATT_IDLE = 2'b00,
      ATT_APR  = 2'b01,
      ATT_REC  = 2'b10
   } att_tmo_state_t;

endpackage : att_pkg

// file: src/att_chan_timeout.sv
// Purpose: one channel of approaching/receding timeout and threshold placement
// Assumes: conv_done is a one-cycle strobe for this channel only
// Notes:   counts conversions, not clock cycles
`timescale 1ns/100ps
`default_nettype none
`include "att_defs.svh"

module att_chan_timeout #(
   parameter int DATA_W = 12,
   parameter int SENS_W = 8,
   parameter int CNT_W  = 16
) (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  clk_en,
   input  wire logic                  conv_done,
   input  wire logic [DATA_W-1:0]     conv_data,
   input  wire logic [DATA_W-1:0]     average,
   input  wire logic [SENS_W-1:0]     sensitivity,
   input  wire logic                  adaptive_en,
   input  wire att_pkg::att_thr_mode_t thr_mode,
   input  wire logic [7:0]            timeout_cfg,
   output logic                       avg_load,
   output logic [DATA_W-1:0]          avg_load_value,
   output logic [DATA_W-1:0]          pos_thr,
   output logic [DATA_W-1:0]          neg_thr,
   output att_pkg::att_tmo_state_t    tmo_state,
   output logic [CNT_W-1:0]           tmo_count
);

   // ----------------------------------------
   // band decode
   // ----------------------------------------
   wire logic [DATA_W:0] band_hi = {1'b0, average} + {{(DATA_W-SENS_W+1){1'b0}}, sensitivity};
   wire logic [DATA_W:0] band_lo = {1'b0, average} - {{(DATA_W-SENS_W+1){1'b0}}, sensitivity};
   wire logic            above   = {1'b0, conv_data} > band_hi;
   // negative low edge means nothing can sit below the band
   wire logic            below   = !band_lo[DATA_W] && (conv_data < band_lo[DATA_W-1:0]);
   wire logic [3:0]      apr_exp = timeout_cfg[`ATT_APR_MSB:`ATT_APR_LSB];
   wire logic [3:0]      rec_exp = timeout_cfg[`ATT_REC_MSB:`ATT_REC_LSB];
   wire logic            tmo_on  = adaptive_en && (timeout_cfg != 8'h00); // see [R1] see [R8]
   wire logic            is_win  = thr_mode == att_pkg::ATT_THR_WIN;
   wire logic            is_neg  = thr_mode == att_pkg::ATT_THR_NEG;
   wire logic            rec_in_win = is_win && (tmo_state == att_pkg::ATT_REC); // see [R5]
   // see [R2]
   wire logic            apr_side = is_win ? (above || below) : (is_neg ? below : above);
   // see [R4] see [R5]
   wire logic            rec_side = !is_win && (is_neg ? above : below);
   wire logic [CNT_W-1:0] apr_target = CNT_W'(1) << apr_exp; // see [R3]
   wire logic [CNT_W-1:0] rec_target = CNT_W'(1) << rec_exp; // see [R6]

   // ----------------------------------------
   // next state
   // ----------------------------------------
   logic [CNT_W-1:0]        apr_base;
   logic [CNT_W-1:0]        rec_base;
   logic [CNT_W-1:0]        next_count;
   logic                    next_fire;
   att_pkg::att_tmo_state_t next_state;

   always_comb begin
      apr_base = '0;
      rec_base = '0;
      case (tmo_state)
         att_pkg::ATT_APR: apr_base = tmo_count;
         att_pkg::ATT_REC: rec_base = tmo_count;
         default: ;
      endcase
   end

   // side change restarts the count at the crossing conversion
   always_comb begin
      next_state = att_pkg::ATT_IDLE;
      next_count = '0;
      next_fire  = 1'b0;
      if (apr_side) begin
         next_count = apr_base + CNT_W'(1); // see [R17]
         // >= covers a target lowered while counting
         if (next_count >= apr_target) begin
            next_fire  = 1'b1;
            next_count = '0;
         end else begin
            next_state = att_pkg::ATT_APR;
         end
      end else if (rec_side) begin
         next_count = rec_base + CNT_W'(1); // see [R17]
         if (next_count >= rec_target) begin
            next_fire  = 1'b1;
            next_count = '0;
         end else begin
            next_state = att_pkg::ATT_REC;
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tmo_state <= att_pkg::ATT_IDLE;
         tmo_count <= '0;
      end else if (clk_en) begin
         if (!tmo_on) begin
            tmo_state <= att_pkg::ATT_IDLE; // see [R1] see [R8]
            tmo_count <= '0;
         end else if (conv_done) begin
            tmo_state <= next_state; // see [R16]
            tmo_count <= next_count;
         end else if (rec_in_win) begin
            // stale recede dies on mode switch
            tmo_state <= att_pkg::ATT_IDLE; // see [R5]
            tmo_count <= '0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         avg_load       <= 1'b0;
         avg_load_value <= '0;
      end else if (clk_en) begin
         avg_load <= conv_done && tmo_on && next_fire; // see [R7] see [R14]
         if (conv_done && tmo_on && next_fire) begin
            avg_load_value <= conv_data; // see [R7] see [R14]
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pos_thr <= '0;
         neg_thr <= '0;
      end else if (clk_en) begin
         // saturate at the code limits
         pos_thr <= band_hi[DATA_W] ? {DATA_W{1'b1}} : band_hi[DATA_W-1:0]; // see [R15]
         neg_thr <= band_lo[DATA_W] ? {DATA_W{1'b0}} : band_lo[DATA_W-1:0]; // see [R15]
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_window_no_recede: assert property ( // see [R5]
      clk_en && is_win |=> tmo_state != att_pkg::ATT_REC)
      else $error("receding timeout ran in window mode");
   a_zero_cfg_idle: assert property (clk_en && timeout_cfg == 8'h00 |=>
      tmo_state == att_pkg::ATT_IDLE && tmo_count == '0) // see [R8]
      else $error("timeout active with zero config");
   a_load_only_adaptive: assert property (avg_load |-> $past(adaptive_en)) // see [R1]
      else $error("average load outside adaptive mode");
   a_fire_exp_zero: assert property (clk_en && conv_done && tmo_on && apr_side && apr_exp == 4'h0
      |=> avg_load && avg_load_value == $past(conv_data)) // see [R3] see [R7]
      else $error("approach timeout of one conversion missed");
   a_inband_clears: assert property (clk_en && conv_done && tmo_on && !above && !below
      |=> tmo_state == att_pkg::ATT_IDLE && tmo_count == '0) // see [R16]
      else $error("count not cleared inside band");
   a_count_step: assert property ( // see [R17]
      clk_en && conv_done && tmo_on && tmo_state == att_pkg::ATT_APR
      && apr_side && tmo_count + CNT_W'(1) < apr_target |=> tmo_count == $past(tmo_count) + 1)
      else $error("approach count did not advance");
   a_count_below_target: assert property ( // see [R6]
      tmo_state == att_pkg::ATT_REC && $past(clk_en && conv_done)
      |-> tmo_count < rec_target || $changed(timeout_cfg))
      else $error("receding count passed its target");
   a_load_is_pulse: assert property (avg_load && $past(clk_en) |-> $past(conv_done)) // see [R7]
      else $error("average load without a conversion");

   c_apr_fire: cover property (tmo_state == att_pkg::ATT_APR ##1 avg_load);
   c_rec_fire: cover property (tmo_state == att_pkg::ATT_REC ##1 avg_load);
   c_side_swap: cover property (tmo_state == att_pkg::ATT_APR ##1 tmo_state == att_pkg::ATT_REC);

endmodule : att_chan_timeout
`default_nettype wire

// file: testbench/att_host_model.sv
// Purpose: host side of the register pointer port
// Assumes: design samples on rising sys_clk
// Notes:   drives only at falling edges
`timescale 1ns/100ps
`default_nettype none
module att_host_model (
   input  wire logic       sys_clk,
   input  wire logic [7:0] reg_rdata,
   output var  logic [7:0] reg_addr,
   output var  logic       reg_wr,
   output var  logic [7:0] reg_wdata
);
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
   end
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   // data inverted after the strobe so a stale value never looks valid
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge sys_clk);
      reg_wr    = 1'b0;
      reg_wdata = ~d;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wr   = 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask : rd_reg
endmodule : att_host_model
`default_nettype wire

// file: testbench/adaptive_threshold_timeout_tb_top.sv
// Purpose: self-checking bench of the timeout and setup registers
// Assumes: one-cycle register and conversion answers as handed over
// Notes:   reset reads first, then register rows, timeout cases by hand after
`timescale 1ns/100ps
`default_nettype none
module adaptive_threshold_timeout_tb_top;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } att_row_t;
   logic                   sys_clk = 1'b0;
   logic                   rst = 1'b1;
   logic                   clk_en = 1'b1;
   logic [7:0]             reg_addr, reg_wdata, reg_rdata, rd;
   logic                   reg_wr, conv_done = 1'b0, conv_ch = 1'b0;
   logic [11:0]            conv_data = 12'h000;
   logic                   ch1_adaptive_en = 1'b1, ch2_adaptive_en = 1'b1;
   att_pkg::att_thr_mode_t ch1_thr_mode = att_pkg::ATT_THR_POS;
   att_pkg::att_thr_mode_t ch2_thr_mode = att_pkg::ATT_THR_POS;
   logic [11:0]            ch1_average = 12'h100, ch2_average = 12'h800;
   logic [7:0]             ch1_sensitivity = 8'h10, ch2_sensitivity = 8'h20;
   logic                   ch1_avg_load, ch2_avg_load, l1, l2;
   logic [11:0]            ch1_avg_load_value, ch2_avg_load_value;
   logic [11:0]            ch1_pos_thr, ch1_neg_thr, ch2_pos_thr, ch2_neg_thr;
   logic                   ch1_range_sel_hi, ch1_range_sel_lo, ch1_hyst_en;
   logic                   ch2_range_sel_hi, ch2_range_sel_lo, ch2_hyst_en;
   logic [3:0]             ch1_threshold_settle_field, ch2_threshold_settle_field;
   int                     n_errors = 0;
   int                     n_checks = 0;
   att_row_t               rows [7] = '{'{8'h0A, 8'h55, 8'h55}, '{8'h0B, 8'hFF, 8'hDF},
      '{8'h0D, 8'h3C, 8'h3C}, '{8'h0E, 8'h20, 8'h00}, '{8'h0C, 8'h77, 8'h00},
      '{8'h0B, 8'hD5, 8'hD5}, '{8'h0E, 8'h6A, 8'h4A}};

   always #12.5 sys_clk = ~sys_clk;

   att_top att_top_i (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done(conv_done),
      .conv_ch(conv_ch), .conv_data(conv_data), .ch1_adaptive_en(ch1_adaptive_en),
      .ch1_thr_mode(ch1_thr_mode), .ch1_average(ch1_average),
      .ch1_sensitivity(ch1_sensitivity), .ch2_adaptive_en(ch2_adaptive_en),
      .ch2_thr_mode(ch2_thr_mode), .ch2_average(ch2_average),
      .ch2_sensitivity(ch2_sensitivity), .ch1_avg_load(ch1_avg_load),
      .ch1_avg_load_value(ch1_avg_load_value), .ch1_pos_thr(ch1_pos_thr),
      .ch1_neg_thr(ch1_neg_thr), .ch2_avg_load(ch2_avg_load),
      .ch2_avg_load_value(ch2_avg_load_value), .ch2_pos_thr(ch2_pos_thr),
      .ch2_neg_thr(ch2_neg_thr), .ch1_range_sel_hi(ch1_range_sel_hi),
      .ch1_range_sel_lo(ch1_range_sel_lo), .ch1_hyst_en(ch1_hyst_en),
      .ch1_threshold_settle_field(ch1_threshold_settle_field),
      .ch2_range_sel_hi(ch2_range_sel_hi), .ch2_range_sel_lo(ch2_range_sel_lo),
      .ch2_hyst_en(ch2_hyst_en), .ch2_threshold_settle_field(ch2_threshold_settle_field));

   att_host_model att_host_model_i (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         n_errors++;
      end
   endtask : chk
   // outputs sampled at the falling edge after the taking edge
   task automatic conv(input logic ch, input logic [11:0] d);
      @(negedge sys_clk);
      conv_done = 1'b1;
      conv_ch   = ch;
      conv_data = d;
      @(negedge sys_clk);
      conv_done = 1'b0;
      conv_data = ~d;
      l1 = ch1_avg_load;
      l2 = ch2_avg_load;
   endtask : conv
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      #(25 * 4000);
      n_errors++;
      report_and_stop();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      rst = 1'b0;
      att_host_model_i.rd_reg(8'h0A, rd); chk("tmo1 reset", 12'h086, rd);
      att_host_model_i.rd_reg(8'h0D, rd); chk("tmo2 reset", 12'h086, rd);
      att_host_model_i.rd_reg(8'h0B, rd); chk("setup1 reset", 12'h00B, rd);
      att_host_model_i.rd_reg(8'h0E, rd); chk("setup2 reset", 12'h00B, rd);
      chk("settle1 reset", 12'h00B, ch1_threshold_settle_field);
      $display("reset test done");
      foreach (rows[i]) begin
         att_host_model_i.wr_reg(rows[i].a, rows[i].d);
         att_host_model_i.rd_reg(rows[i].a, rd);
         chk("reg row", rows[i].e, rd);
      end
      chk("ch1 setup bits", 12'h075,
         {ch1_range_sel_hi, ch1_range_sel_lo, ch1_hyst_en, ch1_threshold_settle_field});
      chk("ch2 setup bits", 12'h02A,
         {ch2_range_sel_hi, ch2_range_sel_lo, ch2_hyst_en, ch2_threshold_settle_field});
      $display("register rows done");
      // frozen cycles must not take a write
      clk_en = 1'b0;
      att_host_model_i.wr_reg(8'h0B, 8'h11);
      clk_en = 1'b1;
      att_host_model_i.rd_reg(8'h0B, rd); chk("frozen write", 12'h0D5, rd);
      chk("pos thr1", 12'h110, ch1_pos_thr);
      chk("neg thr1", 12'h0F0, ch1_neg_thr);
      ch2_average = 12'hFF0;
      repeat (2) @(negedge sys_clk);
      chk("pos thr2 sat", 12'hFFF, ch2_pos_thr);
      chk("neg thr2", 12'hFD0, ch2_neg_thr);
      ch2_average = 12'h800;
      // approach 2 conversions, recede 4 conversions
      att_host_model_i.wr_reg(8'h0A, 8'h12);
      conv(1'b0, 12'h200); chk("apr first", 12'h000, l1);
      conv(1'b0, 12'h201); chk("apr fire", 12'h001, l1);
      chk("apr value", 12'h201, ch1_avg_load_value);
      @(negedge sys_clk);
      chk("load one cycle", 12'h000, ch1_avg_load);
      for (int i = 0; i < 4; i++) begin
         conv(1'b0, 12'h050); chk("rec count", (i == 3) ? 12'h001 : 12'h000, l1);
      end
      chk("rec value", 12'h050, ch1_avg_load_value);
      conv(1'b0, 12'h200);
      conv(1'b0, 12'h100); chk("in band", 12'h000, l1);
      conv(1'b0, 12'h200); chk("restart", 12'h000, l1);
      conv(1'b0, 12'h200); chk("after restart", 12'h001, l1);
      ch1_thr_mode = att_pkg::ATT_THR_NEG;
      conv(1'b0, 12'h050);
      conv(1'b0, 12'h050); chk("neg apr fire", 12'h001, l1);
      conv(1'b0, 12'h200);
      conv(1'b1, 12'h900); chk("other channel", 12'h000, l2);
      conv(1'b0, 12'h200); chk("own channel", 12'h000, l1);
      att_host_model_i.wr_reg(8'h0D, 8'h10);
      conv(1'b1, 12'h901); chk("ch2 fire", 12'h001, l2);
      chk("ch2 value", 12'h901, ch2_avg_load_value);
      $display("timeout counting done");
      // recede after 2 conversions must stay off in window mode
      ch1_thr_mode = att_pkg::ATT_THR_WIN;
      att_host_model_i.wr_reg(8'h0A, 8'hF1);
      conv(1'b0, 12'h050);
      conv(1'b0, 12'h050); chk("window no rec", 12'h000, l1);
      ch1_thr_mode = att_pkg::ATT_THR_POS;
      att_host_model_i.wr_reg(8'h0A, 8'h00);
      repeat (3) begin
         conv(1'b0, 12'h200); chk("zero disables", 12'h000, l1);
      end
      att_host_model_i.wr_reg(8'h0A, 8'h01);
      ch1_adaptive_en = 1'b0;
      conv(1'b0, 12'h200); chk("not adaptive", 12'h000, l1);
      ch1_adaptive_en = 1'b1;
      conv(1'b0, 12'h300); chk("exp zero fire", 12'h001, l1);
      chk("exp zero value", 12'h300, ch1_avg_load_value);
      $display("disable cases done");
      @(negedge sys_clk);
      rst = 1'b1;
      @(negedge sys_clk);
      rst = 1'b0;
      att_host_model_i.rd_reg(8'h0A, rd); chk("second reset", 12'h086, rd);
      chk("value reset", 12'h000, ch1_avg_load_value);
      $display("second reset done");
      report_and_stop();
   end
endmodule : adaptive_threshold_timeout_tb_top
`default_nettype wire
